/* File: pld_pkg.sv */
// shared constants and types for the pll lock detector and vco calibration block
package pld_pkg;

  // ----------------------------------------------------------------
  // clock and bus
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ  = 10_000_000;
  localparam int unsigned AXI_AW  = 8;
  localparam int unsigned AXI_DW  = 32;
  localparam int unsigned REG_W   = 8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // register map: printed offsets are word indices
  // ----------------------------------------------------------------
  localparam int unsigned IDX_LDCAL  = 'h018;
  localparam int unsigned IDX_CNTRST = 'h019;
  localparam logic [AXI_AW-1:0] ADDR_LDCAL    = AXI_AW'(IDX_LDCAL * 4);
  localparam logic [AXI_AW-1:0] ADDR_CNTRST   = AXI_AW'(IDX_CNTRST * 4);
  localparam logic [AXI_AW-1:0] ADDR_UPDATE   = 8'h80;
  localparam logic [AXI_AW-1:0] ADDR_STATUS   = 8'h84;
  localparam logic [AXI_AW-1:0] ADDR_IRQ_ST   = 8'h88;
  localparam logic [AXI_AW-1:0] ADDR_IRQ_MASK = 8'h8c;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int unsigned BIT_CAL_START = 0;
  localparam int unsigned DIV_LSB       = 1;
  localparam int unsigned DIV_MSB       = 2;
  localparam int unsigned BIT_LD_DIS    = 3;
  localparam int unsigned BIT_WIN_LO    = 4;
  localparam int unsigned LDCNT_LSB     = 5;
  localparam int unsigned LDCNT_MSB     = 6;
  localparam int unsigned BIT_UPDATE    = 0;

  localparam logic [REG_W-1:0] LDCAL_RESET  = 8'h06;
  localparam logic [REG_W-1:0] CNTRST_RESET = 8'h00;

  // status and interrupt bits
  localparam int unsigned ST_LOCK   = 0;
  localparam int unsigned ST_BUSY   = 1;
  localparam int unsigned ST_VALID  = 2;
  localparam int unsigned IRQ_W     = 3;
  localparam int unsigned IRQ_LOCK  = 0;
  localparam int unsigned IRQ_LOST  = 1;
  localparam int unsigned IRQ_CAL   = 2;

  // ----------------------------------------------------------------
  // lock detector and calibration
  // ----------------------------------------------------------------
  localparam int unsigned DIFF_W   = 8;
  localparam logic [DIFF_W-1:0] DIFF_MAX = 8'hff;
  localparam logic [1:0] DIV_CODE_16 = 2'h3;

  function automatic logic [7:0] lock_target(input logic [1:0] code);
    unique case (code)
      2'h0: lock_target = 8'h05;
      2'h1: lock_target = 8'h10;
      2'h2: lock_target = 8'h40;
      2'h3: lock_target = 8'hff;
    endcase
  endfunction

  // ratio 2, 4, 8, 16 for codes 0..3
  function automatic logic [4:0] cal_ratio(input logic [1:0] code);
    cal_ratio = 5'(5'h2 << code);
  endfunction

  typedef enum logic {MEAS_IDLE, MEAS_WAIT} pld_meas_t;
  typedef enum logic {CAL_IDLE, CAL_RUN} pld_cal_t;

endpackage

/* File: pld_cal_div.sv */
// vco calibration clock divider and calibration sequencer
module pld_cal_div #(
  parameter int unsigned CAL_STEPS = 32
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ref_tick,
  input  wire logic [1:0] ratio_code,
  input  wire logic       start_bit,
  output logic            cal_clk_en,
  output logic            cal_busy,
  output logic            cal_valid,
  output logic            cal_done
);
  import pld_pkg::*;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  logic [4:0]  div_cnt;
  logic [15:0] step_cnt;
  logic        start_q;
  pld_cal_t    state;

  wire logic [4:0] ratio_m1   = cal_ratio(ratio_code) - 5'h1;
  wire logic       div_wrap   = ref_tick && (div_cnt >= ratio_m1);
  wire logic       start_rise = start_bit && !start_q;
  wire logic       last_step  = cal_clk_en && (step_cnt == 16'(CAL_STEPS - 1));

  // the divider restarts with each calibration so its length is exact
  always_ff @(posedge aclk) begin
    if (!aresetn || start_rise) begin
      div_cnt    <= '0;
      cal_clk_en <= 1'b0;
    end else begin
      cal_clk_en <= div_wrap;
      if (ref_tick) begin
        div_cnt <= div_wrap ? 5'h0 : div_cnt + 5'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencer: steps at the derived clock, so divide-by-16 is longest
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_q   <= 1'b0;
      state     <= CAL_IDLE;
      step_cnt  <= '0;
      cal_busy  <= 1'b0;
      cal_valid <= 1'b0;
      cal_done  <= 1'b0;
    end else begin
      start_q  <= start_bit;
      cal_done <= 1'b0;
      if (!start_bit) begin
        state     <= CAL_IDLE;
        cal_busy  <= 1'b0;
        cal_valid <= 1'b0;
      end else if (start_rise) begin
        state     <= CAL_RUN;
        step_cnt  <= '0;
        cal_busy  <= 1'b1;
        cal_valid <= 1'b0;
      end else begin
        unique case (state)
          CAL_IDLE: begin
          end
          CAL_RUN: begin
            if (cal_clk_en) begin
              step_cnt <= step_cnt + 16'h1;
            end
            if (last_step) begin
              state     <= CAL_IDLE;
              cal_busy  <= 1'b0;
              cal_valid <= 1'b1;
              cal_done  <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_rise;
    start_bit && !start_q;
  endsequence

  property p_cal_start;
    @(posedge aclk) disable iff (!aresetn) s_rise |=> cal_busy ##0 !cal_valid;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("calibration did not start on rising start bit");

  property p_no_retrigger;
    @(posedge aclk) disable iff (!aresetn) $fell(cal_busy) && start_bit && $past(start_bit) |=> !cal_busy;
  endproperty
  a_no_retrigger: assert property (p_no_retrigger) else $error("steady start bit retriggered calibration");

  property p_discard;
    @(posedge aclk) disable iff (!aresetn) !start_bit |=> !cal_valid && !cal_busy;
  endproperty
  a_discard: assert property (p_discard) else $error("cleared start bit kept calibration result");

  property p_div_pulse;
    @(posedge aclk) disable iff (!aresetn) ref_tick && div_cnt == ratio_m1 && !start_rise |=> cal_clk_en;
  endproperty
  a_div_pulse: assert property (p_div_pulse) else $error("divider missed its terminal count");

  property p_div16;
    @(posedge aclk) disable iff (!aresetn)
      cal_clk_en && $past(ratio_code) == DIV_CODE_16 && $past(ratio_code, 2) == DIV_CODE_16 |-> $past(div_cnt) == 5'hf;
  endproperty
  a_div16: assert property (p_div16) else $error("divide by 16 pulse at wrong count");

endmodule

/* File: pld_top.sv */
// pll lock detector, vco calibration control and axi4-lite register file
//
// Contract
// - lock flag sets when edge gap under window
// - lock holds until gap exceeds loss threshold
// - bit 4 picks window range, 0 high
// - bit 3 set disables lock detection
// - calibration clock is reference divided down
// - divider codes give 2, 4, 8, 16
// - divide by 16 gives longest calibration
// - calibration starts only on active 0-to-1
// - clearing start bit discards calibration result
// - lock needs 5, 16, 64, 255 good cycles
//
// Added by the designer: register access over AXI4-Lite.
module pld_top #(
  parameter int unsigned WIN_HI_CYC  = 3,
  parameter int unsigned WIN_LO_CYC  = 1,
  parameter int unsigned LOSS_HI_CYC = 6,
  parameter int unsigned LOSS_LO_CYC = 2,
  parameter int unsigned CAL_STEPS   = 32
) (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic [pld_pkg::AXI_AW-1:0]    awaddr,
  input  wire logic [2:0]                    awprot,
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [pld_pkg::AXI_DW-1:0]    wdata,
  input  wire logic [3:0]                    wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  input  wire logic [pld_pkg::AXI_AW-1:0]    araddr,
  input  wire logic [2:0]                    arprot,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic [pld_pkg::AXI_DW-1:0]         rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  input  wire logic                          ref_edge,
  input  wire logic                          fb_edge,
  input  wire logic                          ref_tick,
  output logic                               lock_indicator,
  output logic                               cal_clk_en,
  output logic                               cal_busy,
  output logic                               cal_valid,
  output logic                               irq
);
  import pld_pkg::*;

  // ----------------------------------------------------------------
  // write channel capture
  // ----------------------------------------------------------------
  logic [AXI_AW-1:0] aw_addr;
  logic              aw_have;
  logic [7:0]        w_data;
  logic              w_lane0;
  logic              w_have;

  wire logic aw_take = awvalid && awready;
  wire logic w_take  = wvalid && wready;
  wire logic wr_go   = aw_have && w_have && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      aw_addr <= '0;
      awready <= 1'b0;
    end else begin
      awready <= !aw_have && !aw_take && !bvalid;
      if (aw_take) begin
        aw_have <= 1'b1;
        aw_addr <= awaddr;
      end else if (wr_go) begin
        aw_have <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have  <= 1'b0;
      w_data  <= '0;
      w_lane0 <= 1'b0;
      wready  <= 1'b0;
    end else begin
      wready <= !w_have && !w_take && !bvalid;
      if (w_take) begin
        w_have  <= 1'b1;
        w_data  <= wdata[7:0];
        w_lane0 <= wstrb[0];
      end else if (wr_go) begin
        w_have <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic wr_ldcal  = wr_go && w_lane0 && aw_addr == ADDR_LDCAL;
  wire logic wr_cntrst = wr_go && w_lane0 && aw_addr == ADDR_CNTRST;
  wire logic wr_update = wr_go && w_lane0 && aw_addr == ADDR_UPDATE && w_data[BIT_UPDATE];
  wire logic wr_mask   = wr_go && w_lane0 && aw_addr == ADDR_IRQ_MASK;
  wire logic wr_hit    = aw_addr == ADDR_LDCAL || aw_addr == ADDR_CNTRST
                      || aw_addr == ADDR_UPDATE || aw_addr == ADDR_IRQ_MASK;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // staging and active copies
  // ----------------------------------------------------------------
  logic [REG_W-1:0] stage_ldcal;
  logic [REG_W-1:0] stage_cntrst;
  logic [REG_W-1:0] act_ldcal;
  logic [REG_W-1:0] act_cntrst;
  logic [IRQ_W-1:0] irq_mask;

  // only the update command moves staged values into the logic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage_ldcal  <= LDCAL_RESET;
      stage_cntrst <= CNTRST_RESET;
      act_ldcal    <= LDCAL_RESET;
      act_cntrst   <= CNTRST_RESET;
      irq_mask     <= '0;
    end else begin
      if (wr_ldcal)  stage_ldcal  <= w_data;
      if (wr_cntrst) stage_cntrst <= w_data;
      if (wr_mask)   irq_mask     <= w_data[IRQ_W-1:0];
      if (wr_update) begin
        act_ldcal  <= stage_ldcal;
        act_cntrst <= stage_cntrst;
      end
    end
  end

  wire logic       ld_disable = act_ldcal[BIT_LD_DIS];
  wire logic       win_low    = act_ldcal[BIT_WIN_LO];
  wire logic [1:0] ld_code    = act_ldcal[LDCNT_MSB:LDCNT_LSB];
  wire logic [1:0] div_code   = act_ldcal[DIV_MSB:DIV_LSB];
  wire logic       cal_start  = act_ldcal[BIT_CAL_START];

  // ----------------------------------------------------------------
  // edge gap measurement
  // ----------------------------------------------------------------
  pld_meas_t         meas_state;
  logic              first_ref;
  logic [DIFF_W-1:0] gap_cnt;
  logic              meas_valid;
  logic [DIFF_W-1:0] meas_diff;

  wire logic [DIFF_W-1:0] win_cyc  = win_low ? DIFF_W'(WIN_LO_CYC) : DIFF_W'(WIN_HI_CYC);
  wire logic [DIFF_W-1:0] loss_cyc = win_low ? DIFF_W'(LOSS_LO_CYC) : DIFF_W'(LOSS_HI_CYC);
  wire logic other_edge = first_ref ? fb_edge : ref_edge;
  wire logic same_edge  = first_ref ? ref_edge : fb_edge;
  // a missing partner edge is scored as a maximal gap, never waited on forever
  wire logic gap_over   = gap_cnt > loss_cyc;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meas_state <= MEAS_IDLE;
      first_ref  <= 1'b0;
      gap_cnt    <= '0;
      meas_valid <= 1'b0;
      meas_diff  <= '0;
    end else begin
      meas_valid <= 1'b0;
      unique case (meas_state)
        MEAS_IDLE: begin
          if (ref_edge && fb_edge) begin
            meas_valid <= 1'b1;
            meas_diff  <= '0;
          end else if (ref_edge || fb_edge) begin
            meas_state <= MEAS_WAIT;
            first_ref  <= ref_edge;
            gap_cnt    <= DIFF_W'(1);
          end
        end
        MEAS_WAIT: begin
          if (other_edge) begin
            meas_state <= MEAS_IDLE;
            meas_valid <= 1'b1;
            meas_diff  <= gap_cnt;
          end else if (same_edge || gap_over) begin
            meas_state <= MEAS_IDLE;
            meas_valid <= 1'b1;
            meas_diff  <= DIFF_MAX;
          end else begin
            gap_cnt <= gap_cnt + DIFF_W'(1);
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // lock decision
  // ----------------------------------------------------------------
  logic [7:0] good_cnt;

  wire logic       in_win     = meas_valid && meas_diff < win_cyc;
  wire logic       beyond     = meas_valid && meas_diff > loss_cyc;
  wire logic [7:0] target_m1  = lock_target(ld_code) - 8'h1;
  wire logic       reach_lock = in_win && good_cnt == target_m1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_indicator <= 1'b0;
      good_cnt       <= '0;
    end else if (ld_disable) begin
      lock_indicator <= 1'b0;
      good_cnt       <= '0;
    end else if (lock_indicator) begin
      if (beyond) begin
        lock_indicator <= 1'b0;
        good_cnt       <= '0;
      end
    end else if (meas_valid) begin
      if (reach_lock) begin
        lock_indicator <= 1'b1;
        good_cnt       <= '0;
      end else begin
        good_cnt <= in_win ? good_cnt + 8'h1 : 8'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // calibration
  // ----------------------------------------------------------------
  logic cal_done;

  pld_cal_div #(
    .CAL_STEPS (CAL_STEPS)
  ) pld_cal_div_i (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .ref_tick   (ref_tick),
    .ratio_code (div_code),
    .start_bit  (cal_start),
    .cal_clk_en (cal_clk_en),
    .cal_busy   (cal_busy),
    .cal_valid  (cal_valid),
    .cal_done   (cal_done)
  );

  // ----------------------------------------------------------------
  // interrupts and read channel
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] irq_status;
  logic             lock_q;

  wire logic rd_take = arvalid && arready;
  wire logic [IRQ_W-1:0] irq_set = {cal_done, lock_q && !lock_indicator, lock_indicator && !lock_q};
  wire logic [IRQ_W-1:0] irq_clr = (rd_take && araddr == ADDR_IRQ_ST) ? '1 : '0;
  // a new event wins over the clearing read in the same cycle
  wire logic [IRQ_W-1:0] next_irq_status = (irq_status & ~irq_clr) | irq_set;
  // a mask write reaches irq in the same edge as the mask itself
  wire logic [IRQ_W-1:0] next_irq_mask   = wr_mask ? w_data[IRQ_W-1:0] : irq_mask;
  wire logic [REG_W-1:0] status_word = REG_W'({cal_valid, cal_busy, lock_indicator});

  wire logic rd_hit = araddr == ADDR_LDCAL || araddr == ADDR_CNTRST || araddr == ADDR_UPDATE
                   || araddr == ADDR_STATUS || araddr == ADDR_IRQ_ST || araddr == ADDR_IRQ_MASK;
  wire logic [REG_W-1:0] rd_word =
      araddr == ADDR_LDCAL    ? stage_ldcal :
      araddr == ADDR_CNTRST   ? stage_cntrst :
      araddr == ADDR_STATUS   ? status_word :
      araddr == ADDR_IRQ_ST   ? REG_W'(irq_status) :
      araddr == ADDR_IRQ_MASK ? REG_W'(irq_mask) : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= '0;
      lock_q     <= 1'b0;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      lock_q     <= lock_indicator;
      irq        <= |(next_irq_status & next_irq_mask);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= !rvalid && !rd_take;
      if (rd_take) begin
        rvalid <= 1'b1;
        rdata  <= AXI_DW'(rd_word);
        rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_lock_set;
    @(posedge aclk) disable iff (!aresetn) !ld_disable && !lock_indicator && reach_lock |=> lock_indicator;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock not set after enough good cycles");

  property p_lock_early;
    @(posedge aclk) disable iff (!aresetn) !lock_indicator && good_cnt < target_m1 |=> !lock_indicator;
  endproperty
  a_lock_early: assert property (p_lock_early) else $error("lock set before enough good cycles");

  property p_hold;
    @(posedge aclk) disable iff (!aresetn) lock_indicator && !ld_disable && !beyond |=> lock_indicator;
  endproperty
  a_hold: assert property (p_hold) else $error("lock dropped without loss of lock");

  property p_window;
    @(posedge aclk) disable iff (!aresetn)
      meas_valid && meas_diff >= (win_low ? DIFF_W'(WIN_LO_CYC) : DIFF_W'(WIN_HI_CYC)) |-> !in_win;
  endproperty
  a_window: assert property (p_window) else $error("gap outside selected window counted as good");

  property p_disable;
    @(posedge aclk) disable iff (!aresetn) ld_disable |=> !lock_indicator && good_cnt == 8'h0;
  endproperty
  a_disable: assert property (p_disable) else $error("disabled detector kept lock or count");

  sequence s_update;
    wr_update ##1 1'b1;
  endsequence

  property p_update;
    @(posedge aclk) disable iff (!aresetn) s_update |-> act_ldcal == $past(stage_ldcal);
  endproperty
  a_update: assert property (p_update) else $error("update command did not load active copy");

  property p_no_update;
    @(posedge aclk) disable iff (!aresetn) !wr_update |=> $stable(act_ldcal);
  endproperty
  a_no_update: assert property (p_no_update) else $error("active copy changed without update");

  property p_irq_level;
    @(posedge aclk) disable iff (!aresetn) irq == |(irq_status & irq_mask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt output disagrees with status and mask");

endmodule

/* File: test_pld_top.sv */
// self-checking bench for the pll lock detector and calibration control block
module test_pld_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pld_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  typedef struct packed {logic [7:0] ctl; int gap; int k; logic lock;} pld_row_t;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        ref_edge = 0, fb_edge = 0, ref_tick = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd, rdata;
  logic [1:0]  rs, bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, lock_indicator, cal_clk_en, cal_busy, cal_valid, irq;
  int          n_mismatch = 0, checked = 0, tick_cnt = 0, last_gap = 0, dur, prev;
  // rows: control value, edge gap in cycles, pairs sent, lock expected
  pld_row_t    rows[8] = '{'{8'h06, 1, 6, 1'b1}, '{8'h06, 3, 6, 1'b0}, '{8'h06, 1, 4, 1'b0},
                           '{8'h16, 1, 6, 1'b0}, '{8'h16, 0, 6, 1'b1}, '{8'h0e, 0, 6, 1'b0},
                           '{8'h26, 1, 15, 1'b0}, '{8'h26, 1, 17, 1'b1}};

  // small step count keeps calibration runs short
  pld_top #(.CAL_STEPS(4)) pld_top_i (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .ref_edge(ref_edge), .fb_edge(fb_edge),
    .ref_tick(ref_tick), .lock_indicator(lock_indicator), .cal_clk_en(cal_clk_en), .cal_busy(cal_busy),
    .cal_valid(cal_valid), .irq(irq));

  always #50 aclk = ~aclk;
  always @(posedge aclk) ref_tick <= ~ref_tick;
  // reference ticks seen between consecutive calibration clock pulses
  always @(posedge aclk) begin
    tick_cnt <= cal_clk_en ? 0 : tick_cnt + int'(ref_tick);
    if (cal_clk_en) last_gap <= tick_cnt;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      n_mismatch++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 50);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
    tmo(n, 50);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
    tmo(n, 50);
  endtask
  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  // staged write then update command, so the value reaches the active copy
  task automatic cfg(input logic [7:0] v);
    wr(ADDR_LDCAL, 32'(v), rs);
    wr(ADDR_UPDATE, 32'h1, rs);
  endtask
  // k detector periods of 13 cycles, feedback edge g cycles after reference edge
  task automatic pairs(input int g, input int k);
    repeat (k) begin
      for (int c = 0; c < 13; c++) begin // 1.3 us period suits every divider code
        ref_edge <= (c == 0);
        fb_edge <= (c == g);
        @(posedge aclk);
      end
    end
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    do_reset();
    rd_reg(ADDR_LDCAL, rd, rs);
    chk(rd, 32'h6);
    rd_reg(8'h90, rd, rs);
    chk(rs, RESP_SLVERR);
    wr(ADDR_STATUS, 32'h1, rs);
    chk(rs, RESP_SLVERR);
    foreach (rows[i]) begin
      do_reset();
      cfg(rows[i].ctl);
      pairs(rows[i].gap, rows[i].k);
      chk(lock_indicator, rows[i].lock);
    end
    // locked detector tolerates a gap between window and loss threshold
    do_reset();
    cfg(8'h06);
    pairs(1, 6);
    pairs(5, 3);
    chk(lock_indicator, 1'b1);
    pairs(11, 1);
    chk(lock_indicator, 1'b0);
    chk(irq, 1'b0);
    rd_reg(ADDR_IRQ_ST, rd, rs);
    chk(rd[1], 1'b1);
    for (int c = 0; c < 4; c++) begin
      do_reset();
      chk(cal_valid, 1'b0);
      wr(ADDR_IRQ_MASK, 32'h4, rs);
      cfg(8'(c << 1));
      cfg(8'(c << 1) | 8'h01);
      dur = 0;
      do begin
        @(posedge aclk);
        dur++;
      end while (cal_valid !== 1'b1 && dur < 1000);
      tmo(dur, 1000);
      @(posedge aclk);
      chk(last_gap, 32'(2 << c));
      if (c > 0) chk(dur > prev, 1'b1);
      prev = dur;
      chk(irq, 1'b1);
      rd_reg(ADDR_IRQ_ST, rd, rs);
      chk(rd[2], 1'b1);
      chk(irq, 1'b0);
    end
    wr(ADDR_UPDATE, 32'h1, rs);
    repeat (4) @(posedge aclk);
    chk(cal_busy, 1'b0);
    wr(ADDR_LDCAL, 32'h6, rs);
    chk(cal_valid, 1'b1);
    wr(ADDR_UPDATE, 32'h1, rs);
    @(posedge aclk);
    chk(cal_valid, 1'b0);
    wr(ADDR_LDCAL, 32'h7, rs);
    repeat (4) @(posedge aclk);
    chk(cal_busy, 1'b0);
    rd_reg(ADDR_STATUS, rd, rs);
    chk(rd, 32'h0);
    stop_test();
  end
endmodule
